/* File: bcm_pkg.sv */
// Shared constants and types for the backplane cycle master.
`default_nettype none
package bcm_pkg;
  // Oscillator is sampled at 200 MHz; time-state clock is oscillator divided by two.
  localparam int OSC_MAX_MHZ = 5;
  localparam int OSC_MIN_MHZ = 1;
  localparam int TSTATE_MIN_NS = 400;
  // Three-stage pin synchroniser depth.
  localparam int SYNC_DEPTH = 3;
  localparam logic [6:0] REFRESH_ROW_RESET = 7'h00;
  localparam logic REFRESH_MSB_RESET = 1'b0;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  // Cycle kinds requested by the core.
  typedef enum logic [2:0] {
    BCM_KIND_FETCH = 3'h0,
    BCM_KIND_MEM_RD = 3'h1,
    BCM_KIND_MEM_WR = 3'h2,
    BCM_KIND_IO_RD = 3'h3,
    BCM_KIND_IO_WR = 3'h4,
    BCM_KIND_ACK = 3'h5
  } bcm_kind_t;
  // Time states of a machine cycle, one-hot.
  typedef enum logic [7:0] {
    BCM_ST_IDLE = 8'h01,
    BCM_ST_T1 = 8'h02,
    BCM_ST_T2 = 8'h04,
    BCM_ST_AUTO1 = 8'h08,
    BCM_ST_AUTO2 = 8'h10,
    BCM_ST_TWAIT = 8'h20,
    BCM_ST_T3 = 8'h40,
    BCM_ST_T4 = 8'h80
  } bcm_state_t;
endpackage
`default_nettype wire

/* File: bcm_pin_sync.sv */
// Three-flop synchroniser for one asynchronous pin, with agreement filter.
`default_nettype none
module bcm_pin_sync #(
  parameter logic RESET_VALUE = 1'b1
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Pin and clean level
  input wire logic i_pin,
  output logic o_level
);
  typedef struct packed {
    logic [bcm_pkg::SYNC_DEPTH-1:0] stage;
    logic level;
  } bcm_sync_state_t;
  bcm_sync_state_t state_ff;
  bcm_sync_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    nxt_state.stage = {state_ff.stage[bcm_pkg::SYNC_DEPTH-2:0], i_pin};
    // Only stages two and three are compared; stage one feeds stage two alone.
    if (state_ff.stage[1] == state_ff.stage[2]) begin
      nxt_state.level = state_ff.stage[2];
    end
  end
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= {{bcm_pkg::SYNC_DEPTH{RESET_VALUE}}, RESET_VALUE};
    end else begin
      state_ff <= nxt_state;
    end
  end
  assign o_level = state_ff.level;
endmodule
`default_nettype wire

/* File: bcm_clock_div.sv */
// Divide-by-two time-state clock generator, producing edge strobes.
`default_nettype none
module bcm_clock_div (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Synchronised oscillator or external clock level
  input wire logic i_osc_level,
  // Time-state clock and its edges
  output logic o_tclk,
  output logic o_rise,
  output logic o_fall
);
  typedef struct packed {
    logic osc_prev;
    logic tclk;
    logic rise;
    logic fall;
  } bcm_div_state_t;
  bcm_div_state_t state_ff;
  bcm_div_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    nxt_state.osc_prev = i_osc_level;
    nxt_state.rise = 1'b0;
    nxt_state.fall = 1'b0;
    // Each rising oscillator edge toggles the time-state clock: divide by two.
    if (i_osc_level && !state_ff.osc_prev) begin
      nxt_state.tclk = !state_ff.tclk;
      nxt_state.rise = !state_ff.tclk;
      nxt_state.fall = state_ff.tclk;
    end
  end
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end
  assign o_tclk = state_ff.tclk;
  assign o_rise = state_ff.rise;
  assign o_fall = state_ff.fall;
endmodule
`default_nettype wire

/* File: bcm_master.sv */
// Backplane cycle master: time-state sequencing, strobes, waits, refresh and DMA yield.
// What this block does
// - Time-state clock is oscillator divided by two.
// - Oscillator at most 5 MHz, 400 ns states.
// - External clock accepted at twice state rate.
// - Every cycle spans whole time states only.
// - Memory and port strobes with proper address.
// - Vector read only via acknowledge, on interrupt.
// - Acknowledge equals fetch marker and port select.
// - Mode one acknowledges but ignores data bus.
// - Acknowledge cycles carry two automatic waits.
// - Acknowledge samples wait in second automatic wait.
// - Port cycles carry one sampled automatic wait.
// - Memory cycles sample wait midway through T2.
// - Waits last while wait request held.
// - Onboard memory reads drive the data bus.
// - Refresh strobe after T3 starts in fetch.
// - Memory select pulses twice per fetch.
// - DMA request answered by DMA grant.
// - Priority chain input wired to output.
// - Grant floats address, data, main strobes.
// - Refresh puts 7-bit row plus set bit.
// - Cycle sync is read, write, acknowledge OR.
// - Fetch marker asserted once per opcode byte.
`default_nettype none
module bcm_master (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Oscillator or external clock pin
  input wire logic i_osc,
  input wire logic i_external_clock_in,
  input wire logic i_use_external_clock,
  // Core cycle requests
  input wire logic i_req_valid,
  input wire logic [2:0] i_req_kind,
  input wire logic [15:0] i_req_addr,
  input wire logic [7:0] i_req_wdata,
  input wire logic i_req_onboard,
  input wire logic [7:0] i_onboard_rdata,
  input wire logic i_irq_mode_one,
  input wire logic i_refresh_preset,
  input wire logic [7:0] i_refresh_preset_value,
  output logic o_req_ready,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  // Backplane pins
  input wire logic i_maskable_irq_n,
  input wire logic i_wait_request_n,
  input wire logic i_dma_request_n,
  input wire logic i_priority_in,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  output logic [15:0] o_addr,
  output logic o_addr_oe_n,
  output logic o_mem_select_n,
  output logic o_io_select_n,
  output logic o_read_n,
  output logic o_write_n,
  output logic o_irq_ack_n,
  output logic o_refresh_n,
  output logic o_cycle_sync_n,
  output logic o_opcode_fetch_marker_n,
  output logic o_strobe_oe_n,
  output logic o_dma_grant_n,
  output logic o_priority_out,
  output logic o_tstate_clock_n,
  output logic o_irq_pending
);
  typedef struct packed {
    bcm_pkg::bcm_state_t st;
    logic [2:0] kind;
    logic onboard;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [6:0] row;
    logic row_msb;
    logic waited;
    logic granted;
    logic done;
    logic [7:0] rdata;
    logic rdata_valid;
    logic mem_sel;
    logic io_sel;
    logic rd;
    logic wr;
    logic marker;
    logic refresh;
    logic drive_data;
    logic [7:0] bus_data;
  } bcm_state_rec_t;

  bcm_state_rec_t state_ff;
  bcm_state_rec_t nxt_state;
  logic osc_pin;
  logic osc_level;
  logic wait_level_n;
  logic dma_level_n;
  logic irq_level_n;
  logic tclk;
  logic ts_rise;
  logic ts_fall;
  logic is_fetch;
  logic is_io;
  logic is_ack;
  logic is_mem;
  logic is_read;
  logic irq_ack;

  // Crystal or external clock, selected by a strap-like input.
  assign osc_pin = i_use_external_clock ? i_external_clock_in : i_osc;

  // System-clock sampling resolves an oscillator of up to 5 MHz with margin.
  bcm_pin_sync #(.RESET_VALUE(1'b0)) u_sync_osc (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_pin(osc_pin),
    .o_level(osc_level)
  );
  bcm_pin_sync #(.RESET_VALUE(1'b1)) u_sync_wait (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_pin(i_wait_request_n),
    .o_level(wait_level_n)
  );
  bcm_pin_sync #(.RESET_VALUE(1'b1)) u_sync_dma (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_pin(i_dma_request_n),
    .o_level(dma_level_n)
  );
  bcm_pin_sync #(.RESET_VALUE(1'b1)) u_sync_irq (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_pin(i_maskable_irq_n),
    .o_level(irq_level_n)
  );

  // All sequencing advances only on divided-clock edges.
  bcm_clock_div u_div (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_osc_level(osc_level),
    .o_tclk(tclk),
    .o_rise(ts_rise),
    .o_fall(ts_fall)
  );

  assign is_fetch = state_ff.kind == bcm_pkg::BCM_KIND_FETCH;
  assign is_ack = state_ff.kind == bcm_pkg::BCM_KIND_ACK;
  assign is_io = state_ff.kind == bcm_pkg::BCM_KIND_IO_RD || state_ff.kind == bcm_pkg::BCM_KIND_IO_WR;
  assign is_mem = !is_io && !is_ack;
  assign is_read = state_ff.kind == bcm_pkg::BCM_KIND_MEM_RD
                   || state_ff.kind == bcm_pkg::BCM_KIND_IO_RD || is_fetch;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.done = 1'b0;
    nxt_state.rdata_valid = 1'b0;
    case (state_ff.st)
      bcm_pkg::BCM_ST_IDLE: begin
        if (ts_rise) begin
          // Grant only between cycles; release resumes driving.
          if (!dma_level_n) begin
            nxt_state.granted = 1'b1;
          end else if (state_ff.granted) begin
            nxt_state.granted = 1'b0;
          end else if (i_req_valid) begin
            nxt_state.kind = i_req_kind;
            nxt_state.addr = i_req_addr;
            nxt_state.wdata = i_req_wdata;
            nxt_state.onboard = i_req_onboard;
            nxt_state.waited = 1'b0;
            nxt_state.st = bcm_pkg::BCM_ST_T1;
            // Marker once per opcode byte fetched, and on acknowledge.
            nxt_state.marker = i_req_kind == bcm_pkg::BCM_KIND_FETCH
                               || i_req_kind == bcm_pkg::BCM_KIND_ACK;
          end
        end
      end
      bcm_pkg::BCM_ST_T1: begin
        if (ts_fall && !is_io && !is_ack) begin
          // Memory strobes with full 16-bit address.
          nxt_state.mem_sel = 1'b1;
          nxt_state.rd = is_read;
        end
        if (ts_rise) begin
          nxt_state.st = bcm_pkg::BCM_ST_T2;
          if (is_io) begin
            // Port cycles carry the low eight address bits only.
            nxt_state.addr = {8'h00, state_ff.addr[7:0]};
            nxt_state.io_sel = 1'b1;
            nxt_state.rd = is_read;
          end
          nxt_state.wr = state_ff.kind == bcm_pkg::BCM_KIND_MEM_WR;
        end
      end
      bcm_pkg::BCM_ST_T2: begin
        // Memory cycles sample wait mid-T2, at the falling state-clock edge.
        if (ts_fall && is_mem) begin
          nxt_state.waited = !wait_level_n;
        end
        if (ts_rise) begin
          nxt_state.wr = state_ff.wr || state_ff.kind == bcm_pkg::BCM_KIND_IO_WR;
          if (is_io || is_ack) begin
            nxt_state.st = bcm_pkg::BCM_ST_AUTO1;
          end else if (state_ff.waited) begin
            nxt_state.st = bcm_pkg::BCM_ST_TWAIT;
          end else begin
            nxt_state.st = bcm_pkg::BCM_ST_T3;
          end
        end
      end
      bcm_pkg::BCM_ST_AUTO1: begin
        if (ts_rise) begin
          if (is_ack) begin
            nxt_state.st = bcm_pkg::BCM_ST_AUTO2;
            // Acknowledge only while fetch marker meets port select.
            nxt_state.io_sel = 1'b1;
          end else begin
            // Port wait sampled at the rising edge of the automatic wait.
            nxt_state.st = wait_level_n ? bcm_pkg::BCM_ST_T3 : bcm_pkg::BCM_ST_TWAIT;
          end
        end
      end
      bcm_pkg::BCM_ST_AUTO2: begin
        if (ts_rise) begin
          // Acknowledge wait sampled in the second automatic wait.
          nxt_state.st = wait_level_n ? bcm_pkg::BCM_ST_T3 : bcm_pkg::BCM_ST_TWAIT;
        end
      end
      bcm_pkg::BCM_ST_TWAIT: begin
        // Held for as long as the request stands, which also single-steps.
        if (ts_rise && wait_level_n) begin
          nxt_state.st = bcm_pkg::BCM_ST_T3;
        end
      end
      bcm_pkg::BCM_ST_T3: begin
        if (ts_rise) begin
          // A fetch took its byte as T3 opened; the others take it now.
          if (!is_fetch) begin
            nxt_state.rdata = state_ff.onboard ? i_onboard_rdata : i_data;
            nxt_state.rdata_valid = is_read || (is_ack && !i_irq_mode_one);
          end
          nxt_state.mem_sel = 1'b0;
          nxt_state.io_sel = 1'b0;
          nxt_state.rd = 1'b0;
          nxt_state.wr = 1'b0;
          nxt_state.marker = 1'b0;
          if (is_fetch) begin
            // Refresh row goes out with its program-set top bit.
            nxt_state.addr = {8'h00, state_ff.row_msb, state_ff.row};
            nxt_state.refresh = 1'b1;
            nxt_state.st = bcm_pkg::BCM_ST_T4;
          end else begin
            nxt_state.done = 1'b1;
            nxt_state.st = bcm_pkg::BCM_ST_IDLE;
          end
        end
        if (ts_fall && is_fetch) begin
          // Second memory-select pulse for the refresh access.
          nxt_state.mem_sel = 1'b1;
        end
      end
      bcm_pkg::BCM_ST_T4: begin
        if (ts_fall) begin
          nxt_state.mem_sel = 1'b0;
        end
        if (ts_rise) begin
          nxt_state.refresh = 1'b0;
          nxt_state.mem_sel = 1'b0;
          nxt_state.row = state_ff.row + 7'h01;
          nxt_state.done = 1'b1;
          nxt_state.st = bcm_pkg::BCM_ST_IDLE;
        end
      end
      default: begin
        nxt_state.st = bcm_pkg::BCM_ST_IDLE;
      end
    endcase
    // A fetch closes its read as T3 opens, so memory select can pulse a second time
    // for refresh and the refresh address is already out before the strobe.
    if (is_fetch && state_ff.st != bcm_pkg::BCM_ST_T3
        && nxt_state.st == bcm_pkg::BCM_ST_T3) begin
      nxt_state.rdata = state_ff.onboard ? i_onboard_rdata : i_data;
      nxt_state.rdata_valid = 1'b1;
      nxt_state.mem_sel = 1'b0;
      nxt_state.rd = 1'b0;
      nxt_state.marker = 1'b0;
      nxt_state.addr = {8'h00, state_ff.row_msb, state_ff.row};
    end
    // Second select pulse must fall in T3 after the refresh address is out.
    if (state_ff.st == bcm_pkg::BCM_ST_T3 && is_fetch && ts_fall) begin
      nxt_state.addr = {8'h00, state_ff.row_msb, state_ff.row};
      nxt_state.refresh = 1'b1;
    end
    if (i_refresh_preset) begin
      nxt_state.row = i_refresh_preset_value[6:0];
      nxt_state.row_msb = i_refresh_preset_value[7];
    end
    // Onboard reads drive data; writes drive the write byte.
    nxt_state.drive_data = (nxt_state.rd && nxt_state.onboard && nxt_state.mem_sel)
                           || nxt_state.wr;
    // Registered, so the bus byte is clean even while the memory input settles.
    nxt_state.bus_data = nxt_state.wr ? nxt_state.wdata : i_onboard_rdata;
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= '{st: bcm_pkg::BCM_ST_IDLE, kind: 3'h0, onboard: 1'b0,
                    addr: bcm_pkg::ADDR_RESET, wdata: 8'h00,
                    row: bcm_pkg::REFRESH_ROW_RESET, row_msb: bcm_pkg::REFRESH_MSB_RESET,
                    waited: 1'b0, granted: 1'b0, done: 1'b0, rdata: 8'h00,
                    rdata_valid: 1'b0, mem_sel: 1'b0, io_sel: 1'b0, rd: 1'b0, wr: 1'b0,
                    marker: 1'b0, refresh: 1'b0, drive_data: 1'b0, bus_data: 8'h00};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign irq_ack = state_ff.marker && state_ff.io_sel;
  assign o_irq_ack_n = !irq_ack;
  assign o_mem_select_n = !state_ff.mem_sel;
  assign o_io_select_n = !(state_ff.io_sel && !state_ff.marker);
  assign o_read_n = !state_ff.rd;
  assign o_write_n = !state_ff.wr;
  assign o_refresh_n = !state_ff.refresh;
  assign o_opcode_fetch_marker_n = !state_ff.marker;
  assign o_cycle_sync_n = !(state_ff.rd || state_ff.wr || irq_ack);
  assign o_addr = state_ff.addr;
  assign o_data = state_ff.bus_data;
  // Floated while granted; otherwise the data bus is driven only for onboard reads and writes.
  assign o_addr_oe_n = state_ff.granted;
  assign o_strobe_oe_n = state_ff.granted;
  assign o_data_oe_n = state_ff.granted || !state_ff.drive_data;
  assign o_dma_grant_n = !state_ff.granted;
  assign o_priority_out = i_priority_in;
  assign o_tstate_clock_n = !tclk;
  assign o_req_ready = state_ff.st == bcm_pkg::BCM_ST_IDLE && ts_rise
                       && dma_level_n && !state_ff.granted;
  assign o_done = state_ff.done;
  assign o_rdata = state_ff.rdata;
  assign o_rdata_valid = state_ff.rdata_valid;
  // Interrupt acknowledge cycles should be started only on this level.
  assign o_irq_pending = !irq_level_n;
endmodule
`default_nettype wire

/* File: bcm_master_asserts.sv */
// Port-level checks for the backplane cycle master.
`default_nettype none
module bcm_master_asserts (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Watched ports
  input wire logic i_priority_in,
  input wire logic o_priority_out,
  input wire logic o_irq_ack_n,
  input wire logic o_opcode_fetch_marker_n,
  input wire logic o_cycle_sync_n,
  input wire logic o_read_n,
  input wire logic o_write_n,
  input wire logic o_mem_select_n,
  input wire logic o_io_select_n,
  input wire logic o_refresh_n,
  input wire logic o_dma_grant_n,
  input wire logic o_addr_oe_n,
  input wire logic o_strobe_oe_n,
  input wire logic o_data_oe_n,
  input wire logic o_req_ready,
  input wire logic o_done,
  input wire logic o_tstate_clock_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  a_ack_with_marker: assert property (!o_irq_ack_n |-> !o_opcode_fetch_marker_n)
    else $error("acknowledge without fetch marker");
  a_chain_through: assert property (o_priority_out == i_priority_in)
    else $error("priority chain altered");
  a_sync_is_or: assert property (!o_strobe_oe_n |->
    o_cycle_sync_n == (o_read_n && o_write_n && o_irq_ack_n))
    else $error("cycle sync differs from strobe OR");
  a_grant_floats: assert property (!o_dma_grant_n |->
    o_addr_oe_n && o_strobe_oe_n && o_data_oe_n)
    else $error("bus driven while granted");
  a_grant_no_take: assert property (!o_dma_grant_n |-> !o_req_ready)
    else $error("request taken while granted");
  a_one_space: assert property (o_mem_select_n || o_io_select_n)
    else $error("memory and port select together");
  a_rd_wr_apart: assert property (o_read_n || o_write_n)
    else $error("read and write together");
  a_refresh_late: assert property ($fell(o_refresh_n) |-> o_read_n && o_write_n)
    else $error("refresh during read strobe");
  a_done_single: assert property (o_done |=> !o_done)
    else $error("done longer than one clock");
  a_tclk_steady: assert property ($changed(o_tstate_clock_n) |=>
    $stable(o_tstate_clock_n) [*3])
    else $error("state clock toggles too fast");
  c_refresh: cover property ($fell(o_refresh_n));
  c_ack: cover property (!o_irq_ack_n);
  c_grant: cover property ($fell(o_dma_grant_n));
endmodule
bind bcm_master bcm_master_asserts chk_u (.i_clock(i_clock), .i_reset(i_reset),
  .i_priority_in(i_priority_in), .o_priority_out(o_priority_out), .o_irq_ack_n(o_irq_ack_n),
  .o_opcode_fetch_marker_n(o_opcode_fetch_marker_n), .o_cycle_sync_n(o_cycle_sync_n),
  .o_read_n(o_read_n), .o_write_n(o_write_n), .o_mem_select_n(o_mem_select_n),
  .o_io_select_n(o_io_select_n), .o_refresh_n(o_refresh_n), .o_dma_grant_n(o_dma_grant_n),
  .o_addr_oe_n(o_addr_oe_n), .o_strobe_oe_n(o_strobe_oe_n), .o_data_oe_n(o_data_oe_n),
  .o_req_ready(o_req_ready), .o_done(o_done), .o_tstate_clock_n(o_tstate_clock_n));
`default_nettype wire

/* File: bcm_far_card.sv */
// Far-side card model: peripheral data, wait requests and DMA requests.
`default_nettype none
module bcm_far_card (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Backplane strobes and address
  input wire logic i_read_n,
  input wire logic i_write_n,
  input wire logic i_irq_ack_n,
  input wire logic i_mem_select_n,
  input wire logic i_io_select_n,
  input wire logic [15:0] i_addr,
  // Bench commands
  input wire logic [7:0] i_hold_clocks,
  input wire logic i_dma_want,
  // Card outputs
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  output var logic o_wait_request_n,
  output var logic o_dma_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_ff;
  logic busy_ff;
  wire logic busy = !(i_read_n && i_write_n && i_irq_ack_n);
  // The upper memory half belongs to the onboard sockets, so the card stays off it.
  assign o_data_oe_n = !(!i_irq_ack_n || (!i_read_n &&
    (!i_io_select_n || (!i_mem_select_n && !i_addr[15]))));
  assign o_data = !i_irq_ack_n ? 8'hC7 : i_addr[7:0] ^ 8'h5A;
  // Held steady from strobe start, so every sampling point sees a clean level.
  assign o_wait_request_n = (left_ff == 8'h00);
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      left_ff <= 8'h00;
      busy_ff <= 1'b0;
      o_dma_request_n <= 1'b1;
    end else begin
      busy_ff <= busy;
      o_dma_request_n <= !i_dma_want;
      if (busy && !busy_ff) begin
        left_ff <= i_hold_clocks;
      end else if (left_ff != 8'h00) begin
        left_ff <= left_ff - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* File: backplane_cycle_master_bench.sv */
// Self-checking bench for the backplane cycle master.
`default_nettype none
module backplane_cycle_master_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ST = 80;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic use_ext = 1'b0, req_valid = 1'b0, req_onboard = 1'b0, mode_one = 1'b0;
  logic ref_load = 1'b0, irq_n = 1'b1, prio_in = 1'b0, dma_want = 1'b0, onb_seen = 1'b0;
  logic [2:0] req_kind = 3'h0;
  logic [5:0] div_ff = 6'h00;
  logic [7:0] req_wdata = 8'h00, onboard_rdata = 8'h00, ref_val = 8'h00, hold_clk = 8'h00;
  logic [15:0] req_addr = 16'h0000, cur_addr = 16'h0000;
  logic [4:0] prev = 5'h1F;
  logic [7:0] exp_q[$];
  int errors = 0, tests_run = 0, cycles = 0, msel_falls = 0, mark_falls = 0, row = 0;
  wire logic o_req_ready, o_done, o_rdata_valid, o_data_oe_n, o_addr_oe_n, mem_n, io_n;
  wire logic rd_n, wr_n, ack_n, ref_n, fm_n, strobe_oe_n, grant_n, irq_pend, p_oe_n;
  wire logic wait_n, dmareq_n;
  wire logic [7:0] o_rdata, o_data, p_data, bus;
  wire logic [15:0] o_addr;
  // A 5 MHz square wave: twenty system clocks low, twenty high.
  wire logic osc_wave = div_ff >= 6'h14;
  // An idle data bus floats to its pull-up level.
  assign bus = !o_data_oe_n ? o_data : (!p_oe_n ? p_data : 8'hFF);
  always #2.5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    div_ff <= (div_ff == 6'h27) ? 6'h00 : div_ff + 6'h01;
    prio_in <= 1'($urandom);
  end
  bcm_master dut_u (.i_clock(i_clock), .i_reset(i_reset),
    .i_osc(use_ext ? 1'b0 : osc_wave), .i_external_clock_in(use_ext ? osc_wave : 1'b0),
    .i_use_external_clock(use_ext), .i_req_valid(req_valid), .i_req_kind(req_kind),
    .i_req_addr(req_addr), .i_req_wdata(req_wdata), .i_req_onboard(req_onboard),
    .i_onboard_rdata(onboard_rdata), .i_irq_mode_one(mode_one), .i_refresh_preset(ref_load),
    .i_refresh_preset_value(ref_val), .o_req_ready(o_req_ready), .o_done(o_done),
    .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid), .i_maskable_irq_n(irq_n),
    .i_wait_request_n(wait_n), .i_dma_request_n(dmareq_n), .i_priority_in(prio_in),
    .i_data(bus), .o_data(o_data), .o_data_oe_n(o_data_oe_n), .o_addr(o_addr),
    .o_addr_oe_n(o_addr_oe_n), .o_mem_select_n(mem_n), .o_io_select_n(io_n),
    .o_read_n(rd_n), .o_write_n(wr_n), .o_irq_ack_n(ack_n), .o_refresh_n(ref_n),
    .o_cycle_sync_n(), .o_opcode_fetch_marker_n(fm_n), .o_strobe_oe_n(strobe_oe_n),
    .o_dma_grant_n(grant_n), .o_priority_out(), .o_tstate_clock_n(), .o_irq_pending(irq_pend));
  bcm_far_card far_u (.i_clock(i_clock), .i_reset(i_reset), .i_read_n(rd_n),
    .i_write_n(wr_n), .i_irq_ack_n(ack_n), .i_mem_select_n(mem_n), .i_io_select_n(io_n),
    .i_addr(o_addr), .i_hold_clocks(hold_clk), .i_dma_want(dma_want), .o_data(p_data),
    .o_data_oe_n(p_oe_n), .o_wait_request_n(wait_n), .o_dma_request_n(dmareq_n));
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wait_clk(input logic want, input bit on_grant);
    int n;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while ((on_grant ? grant_n : o_req_ready) !== want && n < 500);
  endtask
  always @(posedge i_clock) begin
    logic [15:0] m;
    m = io_n ? 16'hFFFF : 16'h00FF;
    prev <= {mem_n, fm_n, rd_n, wr_n, ref_n};
    if (prev[4] && !mem_n) msel_falls++;
    if (prev[3] && !fm_n) mark_falls++;
    if (prev[2] && !rd_n) chk_val(o_addr & m, cur_addr & m);
    if (prev[1] && !wr_n) chk_val({7'h00, o_data_oe_n, o_data}, {8'h00, req_wdata});
    if (prev[0] && !ref_n) begin
      chk_val({8'h00, o_addr[7:0]}, {8'h00, ref_val[7], 7'(row)});
      row++;
    end
    if (!o_data_oe_n && !rd_n && req_onboard) onb_seen = 1'b1;
    if (o_rdata_valid === 1'b1) begin
      if (exp_q.size() == 0) chk_val({8'h00, o_rdata}, 16'hFFFF);
      else chk_val({8'h00, o_rdata}, {8'h00, exp_q.pop_front()});
    end
    cycles++;
    if (cycles == 40000) begin
      errors++;
      close_out();
    end
  end
  task automatic run(input int k, input logic onb, input int w, input int base);
    int n;
    logic [15:0] a;
    a = {onb, 15'($urandom)};
    @(posedge i_clock);
    cur_addr = a;
    req_kind <= 3'(k);
    req_addr <= a;
    req_wdata <= 8'($urandom);
    req_onboard <= onb;
    onboard_rdata <= 8'($urandom);
    hold_clk <= 8'(w * ST);
    req_valid <= 1'b1;
    msel_falls = 0;
    mark_falls = 0;
    onb_seen = 1'b0;
    wait_clk(1'b1, 1'b0);
    req_valid <= 1'b0;
    if (k < 2 || k == 3) exp_q.push_back(onb ? onboard_rdata : a[7:0] ^ 8'h5A);
    if (k == 5 && !mode_one) exp_q.push_back(8'hC7);
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_done !== 1'b1 && n < 3000);
    n = (n + ST / 2) / ST;
    if (w == 0) chk_val(16'(n), 16'(base));
    else chk_val(16'(n > base && n <= base + w + 1), 16'h0001);
    if (k == 0) chk_val(16'(msel_falls * 16 + mark_falls), 16'h0021);
    if (onb) chk_val({15'h0000, onb_seen}, 16'h0001);
  endtask
  initial begin
    int base[6] = '{4, 3, 3, 4, 4, 5};
    logic seen;
    void'($urandom(32'h622023A6));
    repeat (20) @(posedge i_clock);
    i_reset <= 1'b0;
    irq_n <= 1'b0;
    repeat (40) @(posedge i_clock);
    chk_val({15'h0000, irq_pend}, 16'h0001);
    for (int k = 0; k < 6; k++) run(k, 1'b0, 0, base[k]);
    for (int k = 1; k < 6; k += 2) run(k, 1'b0, 2, base[k]);
    run(1, 1'b1, 0, 3);
    $display("test cycles and waits done");
    ref_val <= 8'($urandom);
    ref_load <= 1'b1;
    @(posedge i_clock);
    ref_load <= 1'b0;
    row = int'(ref_val[6:0]);
    repeat (3) run(0, 1'b0, 0, 4);
    $display("test refresh done");
    mode_one <= 1'b1;
    run(5, 1'b0, 0, 5);
    mode_one <= 1'b0;
    irq_n <= 1'b1;
    $display("test mode one done");
    dma_want <= 1'b1;
    wait_clk(1'b0, 1'b1);
    chk_val({15'h0000, grant_n}, 16'h0000);
    req_valid <= 1'b1;
    seen = 1'b0;
    repeat (64) begin
      @(posedge i_clock);
      seen = seen | o_req_ready;
    end
    chk_val({13'h0000, seen, o_addr_oe_n, strobe_oe_n}, 16'h0003);
    req_valid <= 1'b0;
    dma_want <= 1'b0;
    wait_clk(1'b1, 1'b1);
    chk_val({15'h0000, grant_n}, 16'h0001);
    $display("test dma done");
    // Switch while both clock pins sit low, so no short pulse reaches the divider.
    do @(posedge i_clock); while (div_ff != 6'h27);
    use_ext <= 1'b1;
    repeat (40) @(posedge i_clock);
    run(2, 1'b0, 0, 3);
    chk_val(16'(exp_q.size()), 16'h0000);
    $display("test external clock done");
    close_out();
  end
endmodule
`default_nettype wire
